// ### bench/ccm_prom_model.sv
// behavioural serial prom that answers the mac address read frames
// assumes select and clock come from the device pins, data on one wire
`timescale 1ns/1ps
module ccm_prom_model (
    input wire logic cs,
    input wire logic sk,
    input wire logic din,
    output logic dq,
    output logic dq_oe
);
    logic [15:0] mem [0:63];
    logic [8:0] cmd;
    int cnt;
    int reads;
    int bad_cmds;
    int addr_q[$];
    initial begin
        dq = 1'b0;
        dq_oe = 1'b0;
        cnt = 0;
        reads = 0;
        bad_cmds = 0;
    end
    always @(posedge cs) begin
        cnt = 0;
    end
    always @(negedge cs) begin
        dq_oe = 1'b0;
    end
    // data moves just after a clock rise, so it is settled at the next
    always @(posedge sk) begin
        if (cs) begin
            cnt = cnt + 1;
            if (cnt <= 9) begin
                cmd = {cmd[7:0], din};
            end
            if (cnt == 9) begin
                // read only: stored words are never altered
                if (cmd[8:6] != 3'b110) begin
                    bad_cmds = bad_cmds + 1;
                end
                dq_oe = 1'b1;
                dq = 1'b0;
            end else if (cnt >= 10 && cnt <= 25) begin
                dq = mem[cmd[5:0]][25-cnt];
            end else if (cnt == 26) begin
                dq_oe = 1'b0;
                reads = reads + 1;
                addr_q.push_back(int'(cmd[5:0]));
            end
        end
    end
endmodule // ccm_prom_model

// ### bench/testbench.sv
// self-checking bench for the strap, mac and prom pin registers
// assumes the prom model on the pins and a short serial clock half period
`timescale 1ns/1ps
module testbench;
    import ccm_pkg::*;
    localparam int HALF = 8;
    logic clk, rst, clk_prom, reg_wr, reg_rd;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, v, e, w;
    logic endian, wide, present, sel, sck, dout, oe, pin_w, m_q, m_oe;
    logic tb_drv, tb_val;
    logic idle_q = 1'b0;
    logic [7:0] mb [1:6];
    int miscompares, compares;

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        clk_prom = 1'b0;
        #1.3;
        forever #3 clk_prom = ~clk_prom;
    end
    // a wire nobody drives shows a changing level, never a stale one
    always @(posedge clk) idle_q <= ~idle_q;
    assign pin_w = oe ? dout : tb_drv ? tb_val : m_oe ? m_q : idle_q;

    ccm_regs #(.SK_HALF(HALF)) ccm_regs_i (.clk(clk), .rst(rst),
        .clk_prom(clk_prom), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .byte_order_strap_pin(endian), .bus_width_strap_pin(wide),
        .prom_presence_strap_pin(present), .prom_select_pin(sel),
        .prom_clock_pin(sck), .prom_data_pin_o(dout),
        .prom_data_pin_oe(oe), .prom_data_pin_i(pin_w));
    ccm_prom_model ccm_prom_model_i (.cs(sel), .sk(sck), .din(pin_w),
        .dq(m_q), .dq_oe(m_oe));

    task automatic chk(input string nm, input logic [15:0] ex,
        input logic [15:0] got);
        compares++;
        if (got !== ex) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task final_report;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one reset with a given strap set, then config and mac readback
    task automatic strap_run(input int s);
        int j;
        int k;
        @(posedge clk);
        endian <= s[0];
        wide <= s[1];
        present <= s[2];
        rst <= 1'b1;
        for (j = 1; j <= 6; j++) mb[j] = 8'($urandom);
        for (j = 1; j <= 3; j++) begin
            ccm_prom_model_i.mem[j] = {mb[2*j], mb[2*j-1]};
        end
        ccm_prom_model_i.reads = 0;
        ccm_prom_model_i.addr_q.delete();
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (k = 0; k < 4000 && s[2] && ccm_prom_model_i.reads < 3; k++) begin
            @(posedge clk);
        end
        // last word lands after its closing half period and the gap
        repeat (8 * HALF) @(posedge clk);
        chk("load count", s[2] ? 16'h3 : 16'h0,
            16'(ccm_prom_model_i.reads));
        if (ccm_prom_model_i.reads == 3) begin
            for (j = 0; j < 3; j++) begin
                chk("load addr", 16'(j + 1),
                    16'(ccm_prom_model_i.addr_q[j]));
            end
        end
        e = '0;
        e[CFG_ENDIAN_BIT] = s[0];
        e[CFG_PRESENT_BIT] = s[2];
        e[CFG_BUS8_BIT] = !s[1];
        e[CFG_BUS16_BIT] = s[1];
        e[CFG_SHARED_BIT] = 1'b1;
        e[3:0] = CFG_LOW_RSVD;
        rd(OFS_STRAP, v);
        chk("config", e, v);
        for (j = 0; j < 3; j++) begin
            rd(OFS_MAC_LO + 9'(2 * j), v);
            chk("mac word", s[2] ? {mb[2*j+2], mb[2*j+1]} : MAC_RESET,
                v);
        end
    endtask

    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        endian = 1'b0;
        wide = 1'b0;
        present = 1'b0;
        tb_drv = 1'b0;
        tb_val = 1'b0;
        miscompares = 0;
        compares = 0;
        void'($urandom(32'h5e14));
        for (int s = 0; s < 8; s++) strap_run(s);
        for (int j = 0; j < 3; j++) begin
            v = 16'($urandom);
            wr(OFS_MAC_LO + 9'(2 * j), v);
            rd(OFS_MAC_LO + 9'(2 * j), w);
            chk("mac write", v, w);
        end
        chk("prom writes", 16'h0,
            16'(ccm_prom_model_i.bad_cmds));
        wr(OFS_STRAP, 16'hffff);
        wr(9'h116, 16'hffff);
        rd(OFS_STRAP, v);
        chk("config ro", e, v);
        rd(9'h100, v);
        chk("unmapped", 16'h0, v);
        for (int c = 0; c < 64; c++) begin
            @(posedge clk);
            tb_drv <= 1'b1;
            tb_val <= 1'($urandom);
            wr(OFS_PROM, 16'(c));
            repeat (3) @(posedge clk);
            #1;
            if (c[4]) begin
                chk("pins", {12'h0, c[5], c[2], c[1], c[0]},
                    {12'h0, oe, dout, sck, sel});
            end else begin
                chk("pins idle", 16'h0,
                    {12'h0, oe, dout, sck, sel});
            end
            rd(OFS_PROM, v);
            e = {11'h0, c[4], (c[4] && c[5]) ? c[2] : tb_val, c[2], c[1],
                c[0]};
            if (c[4]) begin
                chk("ctl read", e, v);
            end else begin
                chk("ctl read", e, v);
            end
        end
        final_report;
    end

    initial begin
        #200000;
        miscompares++;
        final_report;
    end
endmodule // testbench

// ### src/ccm_pkg.sv
// constants for the strap configuration, host mac and prom pin registers
// assumes a 16-bit register port with byte offsets on 9 address bits
package ccm_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam logic [8:0] OFS_STRAP = 9'h108;
    localparam logic [8:0] OFS_MAC_LO = 9'h110;
    localparam logic [8:0] OFS_MAC_MID = 9'h112;
    localparam logic [8:0] OFS_MAC_HI = 9'h114;
    localparam logic [8:0] OFS_PROM = 9'h122;
    // strap configuration fields
    localparam int CFG_ENDIAN_BIT = 10;
    localparam int CFG_PRESENT_BIT = 9;
    localparam int CFG_BUS8_BIT = 7;
    localparam int CFG_BUS16_BIT = 6;
    localparam int CFG_SHARED_BIT = 4;
    localparam logic [3:0] CFG_LOW_RSVD = 4'h2;
    // prom pin control fields
    localparam int PROM_DIR_BIT = 5;
    localparam int PROM_SW_EN_BIT = 4;
    localparam int PROM_DIN_BIT = 3;
    localparam int PROM_DOUT_BIT = 2;
    localparam int PROM_SK_BIT = 1;
    localparam int PROM_CS_BIT = 0;
    localparam logic [5:0] PROM_CTL_RESET = 6'h00;
    localparam logic [15:0] MAC_RESET = 16'h0000;
    // serial prom read sequence
    localparam int MAC_WORDS = 3;
    localparam logic [5:0] MAC_FIRST_WORD = 6'h01;
    localparam logic [2:0] CMD_READ = 3'h6;
    localparam int CMD_BITS = 9;
    localparam int DATA_BITS = 17;
    // serial clock half period, rounded up to link clock cycles
    localparam int SK_HALF_NS = 250;
    localparam int LINK_PERIOD_NS = 6;
    localparam int SK_HALF_CYC = (SK_HALF_NS + LINK_PERIOD_NS - 1) /
        LINK_PERIOD_NS;
endpackage

// ### src/ccm_prom_if.sv
// signals between the register block and the prom loader
// start comes from clk, everything else is driven on the link clock
`timescale 1ns/1ps
interface ccm_prom_if;
    logic start;
    logic cs;
    logic sk;
    logic dout;
    logic oe;
    logic done;
    logic [2:0][15:0] words;
    modport loader (input start, output cs, sk, dout, oe, done, words);
    modport host (output start, input cs, sk, dout, oe, done, words);
endinterface

// ### src/ccm_prom_loader.sv
// reads the three mac words from a serial prom after reset
// runs on the link clock; start and the data pin arrive unsynchronised
`timescale 1ns/1ps
module ccm_prom_loader
    import ccm_pkg::*;
#(
    parameter int HALF = SK_HALF_CYC
) (
    input wire logic clk_link,
    input wire logic rst_link,
    input wire logic din_pin,
    ccm_prom_if.loader lk
);
    localparam int PH_W = $clog2(2 * HALF);
    typedef enum logic [1:0] {CCM_IDLE, CCM_SHIFT, CCM_GAP, CCM_DONE}
        ccm_ld_state_t;
    ccm_ld_state_t state_q;
    logic start_m_q, start_s_q, din_m_q, din_s_q;
    logic [PH_W-1:0] ph_q;
    logic [4:0] bit_q;
    logic [1:0] idx_q;
    logic [8:0] cmd_q;
    logic [15:0] sh_q;

    function automatic logic [8:0] rd_cmd(input logic [1:0] i);
        rd_cmd = {CMD_READ, MAC_FIRST_WORD + {4'h0, i}};
    endfunction

    always_ff @(posedge clk_link) begin
        start_m_q <= lk.start;
        start_s_q <= start_m_q;
        din_m_q <= din_pin;
        din_s_q <= din_m_q;
    end

    always_ff @(posedge clk_link) begin
        if (rst_link) begin
            state_q <= CCM_IDLE;
            ph_q <= '0;
            bit_q <= 5'h00;
            idx_q <= 2'h0;
            cmd_q <= 9'h000;
            sh_q <= 16'h0000;
            lk.cs <= 1'b0;
            lk.sk <= 1'b0;
            lk.dout <= 1'b0;
            lk.oe <= 1'b0;
            lk.done <= 1'b0;
            lk.words <= '0;
        end else begin
            case (state_q)
                CCM_IDLE: if (start_s_q) begin
                    state_q <= CCM_SHIFT;
                    idx_q <= 2'h0;
                    bit_q <= 5'h00;
                    ph_q <= '0;
                    cmd_q <= {rd_cmd(2'h0)} << 1;
                    // every command opens with the top opcode bit
                    lk.dout <= CMD_READ[2];
                    lk.cs <= 1'b1;
                    lk.oe <= 1'b1;
                end
                CCM_SHIFT: begin
                    ph_q <= ph_q + 1'b1;
                    if (ph_q == PH_W'(HALF - 1)) begin
                        lk.sk <= 1'b1;
                        if (bit_q >= 5'(CMD_BITS))
                            sh_q <= {sh_q[14:0], din_s_q};
                    end
                    if (ph_q == PH_W'(2 * HALF - 1)) begin
                        lk.sk <= 1'b0;
                        ph_q <= '0;
                        if (bit_q == 5'(CMD_BITS + DATA_BITS - 1)) begin
                            lk.words[idx_q] <= sh_q;
                            lk.cs <= 1'b0;
                            state_q <= CCM_GAP;
                        end else begin
                            bit_q <= bit_q + 5'h01;
                            cmd_q <= cmd_q << 1;
                            lk.dout <= cmd_q[8];
                            // read only: the pin is released after the
                            // command, so the prom is never written
                            if (bit_q == 5'(CMD_BITS - 1))
                                lk.oe <= 1'b0;
                        end
                    end
                end
                CCM_GAP: begin
                    ph_q <= ph_q + 1'b1;
                    if (ph_q == PH_W'(2 * HALF - 1)) begin
                        ph_q <= '0;
                        if (idx_q == 2'(MAC_WORDS - 1)) begin
                            state_q <= CCM_DONE;
                            lk.done <= 1'b1;
                        end else begin
                            idx_q <= idx_q + 2'h1;
                            bit_q <= 5'h00;
                            cmd_q <= rd_cmd(idx_q + 2'h1) << 1;
                            lk.dout <= CMD_READ[2];
                            lk.cs <= 1'b1;
                            lk.oe <= 1'b1;
                            state_q <= CCM_SHIFT;
                        end
                    end
                end
                CCM_DONE: if (!start_s_q) begin
                    state_q <= CCM_IDLE;
                    lk.done <= 1'b0;
                end
                default: state_q <= CCM_IDLE;
            endcase
        end
    end

    property p_oe_cmd_only;
        @(posedge clk_link) disable iff (rst_link)
        lk.oe |-> (state_q != CCM_SHIFT || bit_q < 5'(CMD_BITS));
    endproperty
    a_oe_cmd_only: assert property (p_oe_cmd_only)
        else $error("loader drives data pin during data phase");
endmodule // ccm_prom_loader

// ### src/ccm_regs.sv
// strap configuration, host mac address and prom pin control registers
// assumes a simple 16-bit register port on clk and a free link clock
`timescale 1ns/1ps
module ccm_regs
    import ccm_pkg::*;
#(
    parameter int SK_HALF = SK_HALF_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_prom,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic byte_order_strap_pin,
    input wire logic bus_width_strap_pin,
    input wire logic prom_presence_strap_pin,
    output logic prom_select_pin,
    output logic prom_clock_pin,
    output logic prom_data_pin_o,
    output logic prom_data_pin_oe,
    input wire logic prom_data_pin_i
);
    ccm_prom_if lk ();

    // link-side reset, carried over as a level
    logic rst_l_m_q, rst_l_s_q;
    // strap and pin synchronisers
    logic [2:0] strap_m_q, strap_s_q;
    logic din_m_q, din_s_q;
    // loader pins and done, back on clk
    logic [3:0] ld_m_q, ld_s_q;
    logic done_m_q, done_s_q, done_d_q;
    logic done_rise;
    // captured straps: endian, presence, width
    logic strap_endian_q, strap_present_q, strap_wide_q;
    logic load_start_q;
    logic [2:0][15:0] mac_q;
    logic [5:0] ctl_q;
    logic wr_mac_lo, wr_mac_mid, wr_mac_hi, wr_prom;

    function automatic logic [15:0] read_mux(input logic [8:0] a);
        logic [15:0] v;
        v = 16'h0000;
        case (a)
            OFS_STRAP: begin
                v[CFG_ENDIAN_BIT] = strap_endian_q;
                v[CFG_PRESENT_BIT] = strap_present_q;
                v[CFG_BUS8_BIT] = !strap_wide_q;
                v[CFG_BUS16_BIT] = strap_wide_q;
                v[CFG_SHARED_BIT] = 1'b1;
                v[3:0] = CFG_LOW_RSVD;
            end
            OFS_MAC_LO: v = mac_q[0];
            OFS_MAC_MID: v = mac_q[1];
            OFS_MAC_HI: v = mac_q[2];
            OFS_PROM: begin
                // direction is write-only and reads back zero
                v[PROM_SW_EN_BIT] = ctl_q[PROM_SW_EN_BIT];
                v[PROM_DIN_BIT] = din_s_q;
                v[PROM_DOUT_BIT] = ctl_q[PROM_DOUT_BIT];
                v[PROM_SK_BIT] = ctl_q[PROM_SK_BIT];
                v[PROM_CS_BIT] = ctl_q[PROM_CS_BIT];
            end
            default: v = 16'h0000;
        endcase
        read_mux = v;
    endfunction

    ccm_prom_loader #(
        .HALF(SK_HALF)
    ) u_loader (
        .clk_link(clk_prom),
        .rst_link(rst_l_s_q),
        .din_pin(prom_data_pin_i),
        .lk(lk.loader)
    );

    always_ff @(posedge clk_prom) begin
        rst_l_m_q <= rst;
        rst_l_s_q <= rst_l_m_q;
    end

    always_ff @(posedge clk) begin
        strap_m_q <= {byte_order_strap_pin, prom_presence_strap_pin,
            bus_width_strap_pin};
        strap_s_q <= strap_m_q;
        din_m_q <= prom_data_pin_i;
        din_s_q <= din_m_q;
        // skew of a cycle between these bits is harmless: the loader
        // holds each pin level for many cycles
        ld_m_q <= {lk.oe, lk.dout, lk.sk, lk.cs};
        ld_s_q <= ld_m_q;
        done_m_q <= lk.done;
        done_s_q <= done_m_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            // set in reset: a done left over from before reset must not
            // look like a fresh rise and reload stale words
            done_d_q <= 1'b1;
        end else begin
            done_d_q <= done_s_q;
        end
    end

    // words are stable long before done rises, so they may be sampled
    assign done_rise = done_s_q && !done_d_q;

    // straps follow the pins while reset is held and freeze at release
    always_ff @(posedge clk) begin
        if (rst) begin
            strap_endian_q <= strap_s_q[2];
            strap_present_q <= strap_s_q[1];
            strap_wide_q <= strap_s_q[0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            load_start_q <= 1'b0;
        end else begin
            load_start_q <= strap_present_q;
        end
    end

    assign lk.start = load_start_q;

    assign wr_mac_lo = reg_wr && reg_addr == OFS_MAC_LO;
    assign wr_mac_mid = reg_wr && reg_addr == OFS_MAC_MID;
    assign wr_mac_hi = reg_wr && reg_addr == OFS_MAC_HI;
    assign wr_prom = reg_wr && reg_addr == OFS_PROM;

    // the prom load wins over a software write in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            mac_q <= {MAC_RESET, MAC_RESET, MAC_RESET};
        end else if (done_rise) begin
            mac_q <= lk.words;
        end else begin
            // register copy only, nothing goes back to the prom
            if (wr_mac_lo)
                mac_q[0] <= reg_wdata;
            if (wr_mac_mid)
                mac_q[1] <= reg_wdata;
            if (wr_mac_hi)
                mac_q[2] <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_q <= PROM_CTL_RESET;
        end else if (wr_prom) begin
            ctl_q <= reg_wdata[5:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= read_mux(reg_addr);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prom_select_pin <= 1'b0;
            prom_clock_pin <= 1'b0;
            prom_data_pin_o <= 1'b0;
            prom_data_pin_oe <= 1'b0;
        end else if (ctl_q[PROM_SW_EN_BIT]) begin
            prom_select_pin <= ctl_q[PROM_CS_BIT];
            prom_clock_pin <= ctl_q[PROM_SK_BIT];
            prom_data_pin_o <= ctl_q[PROM_DOUT_BIT];
            prom_data_pin_oe <= ctl_q[PROM_DIR_BIT];
        end else begin
            prom_select_pin <= ld_s_q[0];
            prom_clock_pin <= ld_s_q[1];
            prom_data_pin_o <= ld_s_q[2];
            prom_data_pin_oe <= ld_s_q[3];
        end
    end

    sequence s_cfg_read;
        reg_rd && reg_addr == OFS_STRAP;
    endsequence

    sequence s_prom_read;
        reg_rd && reg_addr == OFS_PROM;
    endsequence

    sequence s_word_load;
        done_rise;
    endsequence

    property p_strap_frozen;
        @(posedge clk) disable iff (rst)
        1'b1 |=> $stable({strap_endian_q, strap_present_q, strap_wide_q});
    endproperty
    a_strap_frozen: assert property (p_strap_frozen)
        else $error("strap capture changed outside reset");

    property p_cfg_endian_present;
        @(posedge clk) disable iff (rst)
        s_cfg_read |=> reg_rdata[CFG_ENDIAN_BIT] == strap_endian_q &&
            reg_rdata[CFG_PRESENT_BIT] == strap_present_q;
    endproperty
    a_cfg_endian_present: assert property (p_cfg_endian_present)
        else $error("endian or presence bit wrong on read");

    property p_cfg_width;
        @(posedge clk) disable iff (rst)
        s_cfg_read |=> reg_rdata[CFG_BUS16_BIT] == strap_wide_q &&
            reg_rdata[CFG_BUS8_BIT] != reg_rdata[CFG_BUS16_BIT];
    endproperty
    a_cfg_width: assert property (p_cfg_width)
        else $error("bus width bits wrong on read");

    property p_cfg_shared;
        @(posedge clk) disable iff (rst)
        s_cfg_read |=> reg_rdata[CFG_SHARED_BIT] &&
            reg_rdata[3:0] == CFG_LOW_RSVD && reg_rdata[15:11] == 5'h00;
    endproperty
    a_cfg_shared: assert property (p_cfg_shared)
        else $error("shared bus bit or reserved bits wrong");

    property p_mac_load;
        @(posedge clk) disable iff (rst)
        s_word_load |=> mac_q == $past(lk.words) ##1 $stable(mac_q) ||
            $past(reg_wr);
    endproperty
    a_mac_load: assert property (p_mac_load)
        else $error("mac registers not loaded from prom words");

    property p_mac_write;
        @(posedge clk) disable iff (rst)
        wr_mac_mid && !done_rise |=> mac_q[1] == $past(reg_wdata) &&
            $stable(mac_q[0]) && $stable(mac_q[2]);
    endproperty
    a_mac_write: assert property (p_mac_write)
        else $error("mac middle write wrong or disturbed others");

    property p_sw_pins;
        @(posedge clk) disable iff (rst)
        ctl_q[PROM_SW_EN_BIT] |=>
            prom_select_pin == $past(ctl_q[PROM_CS_BIT]) &&
            prom_clock_pin == $past(ctl_q[PROM_SK_BIT]) &&
            prom_data_pin_o == $past(ctl_q[PROM_DOUT_BIT]);
    endproperty
    a_sw_pins: assert property (p_sw_pins)
        else $error("software pin bits not driving prom pins");

    property p_sw_dir;
        @(posedge clk) disable iff (rst)
        ctl_q[PROM_SW_EN_BIT] |=>
            prom_data_pin_oe == $past(ctl_q[PROM_DIR_BIT]);
    endproperty
    a_sw_dir: assert property (p_sw_dir)
        else $error("data pin direction does not follow control bit");

    property p_din_status;
        @(posedge clk) disable iff (rst)
        s_prom_read |=> reg_rdata[PROM_DIN_BIT] == $past(din_s_q) &&
            reg_rdata[PROM_DIR_BIT] == 1'b0;
    endproperty
    a_din_status: assert property (p_din_status)
        else $error("data pin status bit not live or direction read");

    property p_loader_pins;
        @(posedge clk) disable iff (rst)
        !ctl_q[PROM_SW_EN_BIT] |=>
            {prom_data_pin_oe, prom_data_pin_o, prom_clock_pin,
            prom_select_pin} == $past(ld_s_q);
    endproperty
    a_loader_pins: assert property (p_loader_pins)
        else $error("loader does not own prom pins");

    sequence s_mac_hi_read;
        reg_rd && reg_addr == OFS_MAC_HI;
    endsequence

    sequence s_unmapped_read;
        reg_rd && reg_addr != OFS_STRAP && reg_addr != OFS_MAC_LO &&
            reg_addr != OFS_MAC_MID && reg_addr != OFS_MAC_HI &&
            reg_addr != OFS_PROM;
    endsequence

    property p_mac_read;
        @(posedge clk) disable iff (rst)
        s_mac_hi_read |=> reg_rdata == $past(mac_q[2]);
    endproperty
    a_mac_read: assert property (p_mac_read)
        else $error("mac high word read does not return register");

    property p_unmapped_read;
        @(posedge clk) disable iff (rst)
        s_unmapped_read |=> reg_rdata == 16'h0000;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read returned nonzero data");

    property p_ctl_write;
        @(posedge clk) disable iff (rst)
        wr_prom |=> ctl_q == $past(reg_wdata[5:0]);
    endproperty
    a_ctl_write: assert property (p_ctl_write)
        else $error("prom control bits not taken from write");

    property p_ctl_read;
        @(posedge clk) disable iff (rst)
        s_prom_read |=> reg_rdata[15:6] == 10'h000 &&
            reg_rdata[PROM_SW_EN_BIT] == $past(ctl_q[PROM_SW_EN_BIT]) &&
            reg_rdata[2:0] == $past(ctl_q[2:0]);
    endproperty
    a_ctl_read: assert property (p_ctl_read)
        else $error("prom control read back wrong");

    // antecedent uses sampled reset, so the release edge is skipped
    property p_load_start;
        @(posedge clk) disable iff (rst)
        !rst |=> load_start_q == $past(strap_present_q);
    endproperty
    a_load_start: assert property (p_load_start)
        else $error("prom load request does not follow presence strap");

    property p_rdata_hold;
        @(posedge clk) disable iff (rst)
        !reg_rd && !rst |=> $stable(reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without a read");

    property p_no_false_load;
        @(posedge clk) disable iff (rst)
        !done_s_q |=> $stable(mac_q) || $past(reg_wr);
    endproperty
    a_no_false_load: assert property (p_no_false_load)
        else $error("mac registers changed without load or write");
endmodule // ccm_regs
